// File: classifier_key_pkg.sv
// ==========================================================
// Register map and field layout
package classifier_key_pkg;
  localparam int          ADDR_W           = 8;
  localparam logic [7:0]  CTRL_OFS         = 8'h00;
  localparam logic [7:0]  STATUS_OFS       = 8'h04;
  localparam logic [7:0]  RNG_TYPE_BASE    = 8'h10;
  localparam logic [7:0]  RNG_BOUND_BASE   = 8'h30;
  localparam int          CTRL_DSCP_LSB    = 0;
  localparam int          CTRL_GIDX_LSB    = 4;
  localparam int          CTRL_LPORT_LSB   = 8;
  localparam int          STAT_COUNT_LSB   = 0;
  localparam int          STAT_TYPE_LSB    = 16;
  localparam int          STAT_FIRST_BIT   = 18;
  localparam int          RNG_LOW_LSB      = 0;
  localparam int          RNG_HIGH_LSB     = 16;
  localparam logic [1:0]  DSCP_SEL_RESET   = 2'h0;
  localparam logic [1:0]  GIDX_SEL_RESET   = 2'h0;
  localparam logic [5:0]  LPORT_RESET      = 6'h00;
  localparam logic [2:0]  RNG_TYPE_RESET   = 3'h7;
  localparam logic [31:0] RNG_BOUND_RESET  = 32'h00000000;
  localparam logic [1:0]  RESP_OKAY        = 2'h0;
  localparam logic [1:0]  RESP_SLVERR      = 2'h2;

  // ==========================================================
  // Frame layout constants
  localparam int          HDR_BYTES        = 64;
  localparam logic [8:0]  MAC_BYTES        = 9'h006;
  localparam logic [8:0]  ETYPE_BYTES      = 9'h002;
  localparam logic [8:0]  TAG_BYTES        = 9'h004;
  localparam logic [8:0]  IP4_HDR_BYTES    = 9'h014;
  localparam int          CUSTOM_BYTES     = 15;

  // ==========================================================
  // Encodings
  typedef enum logic [1:0] {
    LOW_LATENCY_FULL_KEY  = 2'b00,
    NORMAL_KEY            = 2'b01,
    NORMAL_FIVE_TUPLE_KEY = 2'b10,
    SECOND_CUSTOM_KEY     = 2'b11
  } wide_key_type_t;

  typedef enum logic [1:0] {
    GIDX_DEF_ZERO  = 2'b00,
    GIDX_DEF_LPORT = 2'b01,
    GIDX_DEF_MASQ  = 2'b10
  } gidx_default_t;

  typedef enum logic [1:0] {
    NEXT_CTRL_DEFAULT = 2'b00,
    NEXT_CTRL_VALUE   = 2'b01,
    NEXT_CTRL_SERVICE = 2'b10,
    NEXT_CTRL_ADD     = 2'b11
  } next_ctrl_t;

  typedef enum logic [2:0] {
    RNG_SPORT  = 3'b000,
    RNG_DPORT  = 3'b001,
    RNG_EITHER = 3'b010,
    RNG_VID    = 3'b011,
    RNG_DSCP   = 3'b100,
    RNG_CUSTOM = 3'b101
  } range_type_t;

  // ==========================================================
  // Carriers
  typedef struct packed {
    logic                   length_type_flag;
    logic                   ip_or_snap_flag;
    logic                   ipv4_flag;
    logic [5:0]             frame_dscp;
    logic [5:0]             classified_dscp;
    logic [5:0]             remapped_dscp;
    logic [31:0]            ipv4_dest;
    logic [31:0]            ipv6_dest_low;
    logic [31:0]            ipv4_src;
    logic [31:0]            ipv6_src_low;
    logic [7:0]             ip_protocol;
    logic [7:0]             ipv6_next_header;
    logic [7:0]             llc_control;
    logic [23:0]            snap_pid;
    logic [31:0]            payload_head;
    logic [15:0]            sport;
    logic [15:0]            dport;
    logic [11:0]            vid;
    logic [15:0]            custom_range_value;
    logic [1:0]             tag_count;
    logic                   pointer_at_eth;
    logic [7:0]             frame_pointer;
    logic [7:0]             ip_header_offset;
    logic [HDR_BYTES*8-1:0] header_bytes;
  } frame_info_t;

  typedef struct packed {
    logic [1:0]  next_index_control;
    logic [11:0] next_index_value;
    logic [11:0] service_index;
  } prev_action_t;

  typedef struct packed {
    logic [1:0]  wide_key_type;
    logic        first_lookup_flag;
    logic [5:0]  logical_ingress_port;
    logic        service_index_flag;
    logic [11:0] generic_chain_index;
  } wide_key_t;

  typedef struct packed {
    logic [5:0]   dscp_key_field;
    logic [31:0]  dest_address_key_field;
    logic [31:0]  overloaded_source_field;
    logic [7:0]   protocol_key_field;
    logic [7:0]   range_match_mask;
    logic [31:0]  post_header_payload;
    logic [119:0] narrow_custom_payload;
  } narrow_key_t;
endpackage

// File: range_checker_bank.sv
`timescale 1ns/100ps
// ==========================================================
// Range checker bank
module range_checker_bank
  import classifier_key_pkg::*;
#(
  parameter int RNG_COUNT = 8
)
(
  // Checker configuration
  input  wire logic [RNG_COUNT*3-1:0]  rng_types,
  input  wire logic [RNG_COUNT*32-1:0] rng_bounds,
  // Frame values
  input  wire frame_info_t             frame,
  // Result
  output      logic [RNG_COUNT-1:0]    mask
);
  // Inclusive bounds check
  function automatic logic in_range(input logic [15:0] v, input logic [31:0] b);
    in_range = (v >= b[RNG_LOW_LSB +: 16]) && (v <= b[RNG_HIGH_LSB +: 16]);
  endfunction

  // Unused type codes never match
  always_comb begin
    for (int i = 0; i < RNG_COUNT; i++) begin
      case (rng_types[i*3 +: 3])
        RNG_SPORT:  mask[i] = in_range(frame.sport, rng_bounds[i*32 +: 32]);
        RNG_DPORT:  mask[i] = in_range(frame.dport, rng_bounds[i*32 +: 32]);
        RNG_EITHER: mask[i] = in_range(frame.sport, rng_bounds[i*32 +: 32]) ||
                              in_range(frame.dport, rng_bounds[i*32 +: 32]);
        RNG_VID:    mask[i] = in_range({4'h0, frame.vid}, rng_bounds[i*32 +: 32]);
        // Remapped DSCP, not the frame's
        RNG_DSCP:   mask[i] = in_range({10'h000, frame.remapped_dscp},
                                       rng_bounds[i*32 +: 32]);
        RNG_CUSTOM: mask[i] = in_range(frame.custom_range_value, rng_bounds[i*32 +: 32]);
        default:    mask[i] = 1'b0;
      endcase
    end
  end
endmodule // range_checker_bank

// File: classifier_key_builder.sv
// Decided for this implementation: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/100ps
// ==========================================================
// Overview of operation
// - Wide key type: 0 low-latency full, 1 normal, 2 five-tuple, 3 custom.
// - Wide key order flag: one in the first lookup, zero in the second.
// - Only the low-latency full key carries the 6-bit logical port.
// - Other keys flag a service index chosen by the last action.
// - Those keys carry a 12-bit chaining index from the last action.
// - Chaining index default: zero, logical port or masqueraded port.
// - DSCP field: frame DSCP, or classified DSCP when enabled per lookup.
// - Destination field: IPv4 address, or IPv6 address bits 31:0.
// - LLC frames: source field is control byte and payload bytes 0 to 2.
// - SNAP frames: source field is protocol identifier bytes 2:0, payload byte 0.
// - IP frames: source field is IPv4 source, else IPv6 source bits 31:0.
// - Other frames: source field is payload bytes 0 to 3.
// - Protocol field: IPv4 protocol, or IPv6 next header.
// - 8-bit range mask from checkers on ports, VID, remapped DSCP and custom data.
// - Post-header payload is always 20 bytes after the IPv4 header start.
// - Narrow custom payload: 15 bytes from the current frame pointer.
// - At Ethernet layer it starts after both MACs, 0 to 3 tags and EtherType.
module classifier_key_builder
  import classifier_key_pkg::*;
#(
  parameter int RNG_COUNT = 8
)
(
  // Clock and reset
  input  wire logic               aclk,
  input  wire logic               aresetn,
  // AXI4-Lite write address and data
  input  wire logic [ADDR_W-1:0]  awaddr,
  input  wire logic               awvalid,
  output      logic               awready,
  input  wire logic [31:0]        wdata,
  input  wire logic [3:0]         wstrb,
  input  wire logic               wvalid,
  output      logic               wready,
  // AXI4-Lite write response
  output      logic [1:0]         bresp,
  output      logic               bvalid,
  input  wire logic               bready,
  // AXI4-Lite read
  input  wire logic [ADDR_W-1:0]  araddr,
  input  wire logic               arvalid,
  output      logic               arready,
  output      logic [31:0]        rdata,
  output      logic [1:0]         rresp,
  output      logic               rvalid,
  input  wire logic               rready,
  // Lookup request from the parser
  input  wire logic               lookup_valid,
  input  wire logic               lookup_first,
  input  wire wide_key_type_t     lookup_key_type,
  input  wire frame_info_t        frame,
  input  wire prev_action_t       prev_action,
  input  wire logic [5:0]         masq_port_number,
  // Keys towards the match array
  output      logic               key_valid,
  output      wide_key_t          wide_key,
  output      narrow_key_t        narrow_key
);
  localparam int IDX_W = $clog2(RNG_COUNT);

  // ==========================================================
  // Shared helpers

  // Aligned word inside a table of RNG_COUNT words
  function automatic logic table_hit(input logic [ADDR_W-1:0] a,
                                     input logic [ADDR_W-1:0] base);
    table_hit = (a >= base) && (a < base + ADDR_W'(RNG_COUNT * 4)) && (a[1:0] == 2'h0);
  endfunction

  // Word index in the table
  function automatic logic [IDX_W-1:0] table_idx(input logic [ADDR_W-1:0] a,
                                                 input logic [ADDR_W-1:0] base);
    logic [ADDR_W-1:0] d;
    d = a - base;
    table_idx = d[IDX_W+1:2];
  endfunction

  // Byte merge by strobes
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0]  s);
    for (int i = 0; i < 4; i++) begin
      merge[i*8 +: 8] = s[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
    end
  endfunction

  // Fifteen bytes, first in the top lane;
  // past the window reads zero, no wrap
  function automatic logic [119:0] grab(input logic [HDR_BYTES*8-1:0] hdr,
                                        input logic [8:0]             ofs);
    logic [9:0] p;
    for (int i = 0; i < CUSTOM_BYTES; i++) begin
      p = {1'b0, ofs} + 10'(i);
      if (p < 10'(HDR_BYTES)) begin
        grab[119-8*i -: 8] = hdr[p*8 +: 8];
      end else begin
        grab[119-8*i -: 8] = 8'h00;
      end
    end
  endfunction

  // ==========================================================
  // Config and status registers
  logic [1:0]            use_cl_dscp_reg;
  logic [1:0]            gidx_sel_reg;
  logic [5:0]            lport_reg;
  logic [2:0]            rng_type_reg  [RNG_COUNT];
  logic [31:0]           rng_bound_reg [RNG_COUNT];
  logic [15:0]           key_count_reg;
  logic [1:0]            last_type_reg;
  logic                  last_first_reg;
  logic [RNG_COUNT*3-1:0]  rng_types_flat;
  logic [RNG_COUNT*32-1:0] rng_bounds_flat;

  // Flat checker tables for the bank
  always_comb begin
    for (int i = 0; i < RNG_COUNT; i++) begin
      rng_types_flat[i*3 +: 3]   = rng_type_reg[i];
      rng_bounds_flat[i*32 +: 32] = rng_bound_reg[i];
    end
  end

  // Control word
  wire logic [31:0] ctrl_word = {18'h00000, lport_reg, 2'h0, gidx_sel_reg,
                                 2'h0, use_cl_dscp_reg};
  wire logic [31:0] status_word = {13'h0000, last_first_reg, last_type_reg,
                                   key_count_reg};

  // ==========================================================
  // AXI4-Lite write side
  logic                  aw_held_reg;
  logic                  w_held_reg;
  logic [ADDR_W-1:0]     awaddr_reg;
  logic [31:0]           wdata_reg;
  logic [3:0]            wstrb_reg;
  logic                  bvalid_reg;
  logic [1:0]            bresp_reg;

  // Address and data in either order, each held until both are
  assign awready = !aw_held_reg && !bvalid_reg;
  assign wready  = !w_held_reg && !bvalid_reg;
  assign bvalid  = bvalid_reg;
  assign bresp   = bresp_reg;

  // Write decode, held address
  wire logic             do_write   = aw_held_reg && w_held_reg && !bvalid_reg;
  wire logic             wr_ctrl    = (awaddr_reg == CTRL_OFS);
  wire logic             wr_status  = (awaddr_reg == STATUS_OFS);
  wire logic             wr_type    = table_hit(awaddr_reg, RNG_TYPE_BASE);
  wire logic             wr_bound   = table_hit(awaddr_reg, RNG_BOUND_BASE);
  wire logic [IDX_W-1:0] wr_tidx    = table_idx(awaddr_reg, RNG_TYPE_BASE);
  wire logic [IDX_W-1:0] wr_bidx    = table_idx(awaddr_reg, RNG_BOUND_BASE);
  wire logic             wr_mapped  = wr_ctrl || wr_status || wr_type || wr_bound;
  wire logic [31:0]      ctrl_new   = merge(ctrl_word, wdata_reg, wstrb_reg);
  wire logic [31:0]      type_new   = merge({29'h0, rng_type_reg[wr_tidx]},
                                            wdata_reg, wstrb_reg);
  wire logic [31:0]      bound_new  = merge(rng_bound_reg[wr_bidx], wdata_reg, wstrb_reg);

  // Channel holding and response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_reg <= 1'b0;
      w_held_reg  <= 1'b0;
      awaddr_reg  <= '0;
      wdata_reg   <= 32'h00000000;
      wstrb_reg   <= 4'h0;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= RESP_OKAY;
    end else begin
      if (awvalid && awready) begin
        aw_held_reg <= 1'b1;
        awaddr_reg  <= awaddr;
      end
      if (wvalid && wready) begin
        w_held_reg <= 1'b1;
        wdata_reg  <= wdata;
        wstrb_reg  <= wstrb;
      end
      if (do_write) begin
        aw_held_reg <= 1'b0;
        w_held_reg  <= 1'b0;
        bvalid_reg  <= 1'b1;
        bresp_reg   <= wr_mapped ? RESP_OKAY : RESP_SLVERR; // Status read-only, ignored
      end else if (bvalid_reg && bready) begin
        bvalid_reg <= 1'b0;
      end
    end
  end

  // Register storage
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      use_cl_dscp_reg <= DSCP_SEL_RESET;
      gidx_sel_reg    <= GIDX_SEL_RESET;
      lport_reg       <= LPORT_RESET;
      for (int i = 0; i < RNG_COUNT; i++) begin
        rng_type_reg[i]  <= RNG_TYPE_RESET;
        rng_bound_reg[i] <= RNG_BOUND_RESET;
      end
    end else if (do_write) begin
      if (wr_ctrl) begin
        use_cl_dscp_reg <= ctrl_new[CTRL_DSCP_LSB +: 2];
        gidx_sel_reg    <= ctrl_new[CTRL_GIDX_LSB +: 2];
        lport_reg       <= ctrl_new[CTRL_LPORT_LSB +: 6];
      end
      if (wr_type) begin
        rng_type_reg[wr_tidx] <= type_new[2:0];
      end
      if (wr_bound) begin
        rng_bound_reg[wr_bidx] <= bound_new;
      end
    end
  end

  // ==========================================================
  // AXI4-Lite read side
  logic                  rvalid_reg;
  logic [31:0]           rdata_reg;
  logic [1:0]            rresp_reg;

  // One read in flight; next address waits for rready
  assign arready = !rvalid_reg;
  assign rvalid  = rvalid_reg;
  assign rdata   = rdata_reg;
  assign rresp   = rresp_reg;

  // Read decode on the offered address
  wire logic             rd_ctrl   = (araddr == CTRL_OFS);
  wire logic             rd_status = (araddr == STATUS_OFS);
  wire logic             rd_type   = table_hit(araddr, RNG_TYPE_BASE);
  wire logic             rd_bound  = table_hit(araddr, RNG_BOUND_BASE);
  wire logic [IDX_W-1:0] rd_tidx   = table_idx(araddr, RNG_TYPE_BASE);
  wire logic [IDX_W-1:0] rd_bidx   = table_idx(araddr, RNG_BOUND_BASE);
  wire logic             rd_mapped = rd_ctrl || rd_status || rd_type || rd_bound;
  wire logic [31:0]      rd_word   = rd_ctrl   ? ctrl_word :
                                     rd_status ? status_word :
                                     rd_type   ? {29'h0, rng_type_reg[rd_tidx]} :
                                     rd_bound  ? rng_bound_reg[rd_bidx] : 32'h00000000;

  // Read data capture
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_reg <= 1'b0;
      rdata_reg  <= 32'h00000000;
      rresp_reg  <= RESP_OKAY;
    end else if (arvalid && arready) begin
      rvalid_reg <= 1'b1;
      rdata_reg  <= rd_word;
      rresp_reg  <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid_reg && rready) begin
      rvalid_reg <= 1'b0;
    end
  end

  // ==========================================================
  // Narrow key fields
  logic [RNG_COUNT-1:0]  rng_mask;

  range_checker_bank #(
    .RNG_COUNT (RNG_COUNT)
  ) u_ranges (
    .rng_types  (rng_types_flat),
    .rng_bounds (rng_bounds_flat),
    .frame      (frame),
    .mask       (rng_mask)
  );

  // Classified DSCP per lookup: bit 0 first, bit 1 second
  wire logic       dscp_use_cl = lookup_first ? use_cl_dscp_reg[0] : use_cl_dscp_reg[1];
  wire logic [5:0] dscp_next   = dscp_use_cl ? frame.classified_dscp
                                             : frame.frame_dscp;

  wire logic [31:0] dest_next  = frame.ipv4_flag ? frame.ipv4_dest
                                                 : frame.ipv6_dest_low;
  wire logic [7:0]  proto_next = frame.ipv4_flag ? frame.ip_protocol
                                                 : frame.ipv6_next_header;

  // Overloaded source field by frame class
  logic [31:0] source_next;
  always_comb begin
    case ({frame.length_type_flag, frame.ip_or_snap_flag})
      2'b00:   source_next = {frame.llc_control, frame.payload_head[31:8]};
      2'b01:   source_next = {frame.snap_pid, frame.payload_head[31:24]};
      2'b11:   source_next = frame.ipv4_flag ? frame.ipv4_src
                                             : frame.ipv6_src_low;
      default: source_next = frame.payload_head;
    endcase
  end

  // IPv4 options never skipped: offset fixed past the base header
  wire logic [8:0]   post_ofs    = {1'b0, frame.ip_header_offset} + IP4_HDR_BYTES;
  wire logic [119:0] post_bytes  = grab(frame.header_bytes, post_ofs);
  wire logic [31:0]  post_next   = post_bytes[119:88];

  // Ethernet start: two MACs, the tags, then EtherType
  wire logic [8:0]   eth_ofs     = MAC_BYTES + MAC_BYTES + ETYPE_BYTES +
                                   9'(TAG_BYTES * {7'h00, frame.tag_count});
  wire logic [8:0]   custom_ofs  = frame.pointer_at_eth ? eth_ofs
                                                        : {1'b0, frame.frame_pointer};
  wire logic [119:0] custom_next = grab(frame.header_bytes, custom_ofs);

  // ==========================================================
  // Wide key fields
  logic [11:0] gidx_default;
  logic [11:0] gidx_next;
  logic        service_next;

  // Chaining index default
  always_comb begin
    case (gidx_sel_reg)
      GIDX_DEF_LPORT: gidx_default = {6'h00, lport_reg};
      GIDX_DEF_MASQ:  gidx_default = {6'h00, masq_port_number};
      default:        gidx_default = 12'h000;
    endcase
  end

  // Chaining from the last action; service also raises its flag
  always_comb begin
    service_next = 1'b0;
    case (prev_action.next_index_control)
      NEXT_CTRL_VALUE:   gidx_next = prev_action.next_index_value;
      NEXT_CTRL_SERVICE: begin
        gidx_next    = prev_action.service_index;
        service_next = 1'b1;
      end
      NEXT_CTRL_ADD:     gidx_next = gidx_default + prev_action.next_index_value;
      default:           gidx_next = gidx_default;
    endcase
  end

  // Absent fields are zero so entries match cleanly
  wire logic       is_low_latency_full_key = (lookup_key_type == LOW_LATENCY_FULL_KEY);
  wire wide_key_t  wide_next  = '{
    wide_key_type:        lookup_key_type,
    first_lookup_flag:    lookup_first,
    logical_ingress_port: is_low_latency_full_key ? lport_reg : 6'h00,
    service_index_flag:   is_low_latency_full_key ? 1'b0 : service_next,
    generic_chain_index:  is_low_latency_full_key ? 12'h000 : gidx_next
  };

  wire narrow_key_t narrow_next = '{
    dscp_key_field:          dscp_next,
    dest_address_key_field:  dest_next,
    overloaded_source_field: source_next,
    protocol_key_field:      proto_next,
    range_match_mask:        8'(rng_mask),
    post_header_payload:     post_next,
    narrow_custom_payload:   custom_next
  };

  // ==========================================================
  // One cycle from request to key, no back-pressure
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      key_valid  <= 1'b0;
      wide_key   <= '0;
      narrow_key <= '0;
    end else begin
      key_valid <= lookup_valid;
      if (lookup_valid) begin
        wide_key   <= wide_next;
        narrow_key <= narrow_next;
      end
    end
  end

  // Status: key count, last type and order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      key_count_reg  <= 16'h0000;
      last_type_reg  <= 2'h0;
      last_first_reg <= 1'b0;
    end else if (lookup_valid) begin
      key_count_reg  <= key_count_reg + 16'h0001; // Wraps
      last_type_reg  <= lookup_key_type;
      last_first_reg <= lookup_first;
    end
  end
endmodule // classifier_key_builder

// File: key_monitor.sv
`timescale 1ns/100ps
// ==========================================================
// Lookup key checks
module key_monitor
  import classifier_key_pkg::*;
(
  input wire logic           aclk,
  input wire logic           aresetn,
  input wire logic           lookup_valid,
  input wire logic           lookup_first,
  input wire wide_key_type_t lookup_key_type,
  input wire frame_info_t    frame,
  input wire logic           key_valid,
  input wire wide_key_t      wide_key,
  input wire narrow_key_t    narrow_key
);
  frame_info_t f_q;
  // Frame at the lookup edge
  always_ff @(posedge aclk) f_q <= frame;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  property p_kv; lookup_valid |=> key_valid; endproperty
  property p_hold; !lookup_valid |=> !key_valid && $stable(wide_key); endproperty
  property p_ty; lookup_valid |=> wide_key.wide_key_type == $past(lookup_key_type); endproperty
  property p_fl; lookup_valid |=> wide_key.first_lookup_flag == $past(lookup_first); endproperty
  property p_pt; lookup_valid && lookup_key_type != 0 |=> wide_key.logical_ingress_port == 0;
  endproperty
  property p_gx; lookup_valid && lookup_key_type == 0
    |=> {wide_key.service_index_flag, wide_key.generic_chain_index} == 0; endproperty
  property p_da; lookup_valid |=> narrow_key.dest_address_key_field
    == (f_q.ipv4_flag ? f_q.ipv4_dest : f_q.ipv6_dest_low); endproperty
  property p_pr; lookup_valid |=> narrow_key.protocol_key_field
    == (f_q.ipv4_flag ? f_q.ip_protocol : f_q.ipv6_next_header); endproperty
  a_kv: assert property (p_kv) else $error("no key strobe");
  a_hold: assert property (p_hold) else $error("key moved");
  a_ty: assert property (p_ty) else $error("key type");
  a_fl: assert property (p_fl) else $error("first flag");
  a_pt: assert property (p_pt) else $error("port leak");
  a_gx: assert property (p_gx) else $error("chain on full key");
  a_da: assert property (p_da) else $error("dest field");
  a_pr: assert property (p_pr) else $error("proto field");
  c_ll: cover property (lookup_valid && lookup_key_type == LOW_LATENCY_FULL_KEY);
  c_cu: cover property (lookup_valid && lookup_key_type == SECOND_CUSTOM_KEY);
  c_sv: cover property (key_valid && wide_key.service_index_flag);
endmodule // key_monitor
bind classifier_key_builder key_monitor mon (.aclk, .aresetn, .lookup_valid, .lookup_first,
  .lookup_key_type, .frame, .key_valid, .wide_key, .narrow_key);

// File: parser_model.sv
`timescale 1ns/100ps
// ==========================================================
// Parser side: one-cycle strobe
module parser_model
  import classifier_key_pkg::*;
(
  input wire logic       aclk,
  output logic           lookup_valid = 1'b0,
  output logic           lookup_first = 1'b0,
  output wide_key_type_t lookup_key_type = NORMAL_KEY,
  output frame_info_t    frame = '0,
  output prev_action_t   prev_action = '0
);
  // Scrambled after strobe
  task automatic send(input logic f, input wide_key_type_t t, input frame_info_t fi,
                      input prev_action_t pa);
    @(posedge aclk);
    {lookup_valid, lookup_first, lookup_key_type, frame, prev_action} <= {1'b1, f, t, fi, pa};
    @(posedge aclk);
    {lookup_valid, frame, prev_action} <= {1'b0, ~fi, ~pa};
  endtask
endmodule // parser_model

// File: testbench.sv
`timescale 1ns/100ps
// ==========================================================
// Register and key tests
module testbench;
  import classifier_key_pkg::*;
  logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [7:0] awaddr = '0, araddr = '0;
  logic [31:0] wdata = '0, rdata, rd_v;
  logic [3:0] wstrb = 4'hf;
  logic awready, wready, bvalid, arready, rvalid, lookup_valid, lookup_first, key_valid;
  logic [1:0] bresp, rresp, rs;
  logic [5:0] masq_port_number = 6'h15;
  logic [119:0] cexp;
  logic [11:0] gx [8] = '{0, 12'h2a, 12'h100, 12'h345, 12'h12a, 0, 12'h2a, 12'h15};
  logic [31:0] se [5] = '{32'h3c818283, 32'h4d5e6f81, 32'h11223344, 32'h55667788, 32'h81828384};
  logic [2:0] fl [5] = '{3'b000, 3'b010, 3'b111, 3'b110, 3'b100};
  wide_key_type_t lookup_key_type;
  frame_info_t frame, fr;
  prev_action_t prev_action, pa;
  wide_key_t wide_key;
  narrow_key_t narrow_key;
  int miscompares = 0, tests_run = 0;
  parser_model pm (.aclk, .lookup_valid, .lookup_first, .lookup_key_type, .frame, .prev_action);
  classifier_key_builder dut (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb,
    .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp,
    .rvalid, .rready, .lookup_valid, .lookup_first, .lookup_key_type, .frame, .prev_action,
    .masq_port_number, .key_valid, .wide_key, .narrow_key);
  initial forever #25 aclk = ~aclk;
  task automatic chk(input string n, input logic [119:0] s, e);
    tests_run++;
    if (s !== e) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // Channels drop when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    {awaddr, wdata, awvalid, wvalid, bready} <= {a, d, 3'b111};
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 0;
      if (wready) wvalid <= 0;
    end while (bvalid !== 1'b1);
    rs = bresp;
    bready <= 0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge aclk);
    {araddr, arvalid, rready} <= {a, 2'b11};
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 0;
    end while (rvalid !== 1'b1);
    {rd_v, rs} = {rdata, rresp};
    rready <= 0;
  endtask
  task automatic lk(input logic f, input wide_key_type_t t);
    pm.send(f, t, fr, pa);
    @(negedge aclk);
    chk("key_valid", key_valid, 1);
  endtask
  // Watchdog
  initial begin
    #400000;
    miscompares++;
    end_of_test;
  end
  initial begin
    fr = '0;
    for (int i = 0; i < 64; i++) fr.header_bytes[8*i+:8] = 8'(i);
    for (int k = 0; k < 15; k++) cexp[119-8*k-:8] = 8'(22 + k);
    {fr.llc_control, fr.snap_pid, fr.payload_head} = {8'h3c, 24'h4d5e6f, 32'h81828384};
    {fr.ipv4_src, fr.ipv6_src_low, fr.ipv4_dest} = {32'h11223344, 32'h55667788, 32'h01020304};
    {fr.ip_protocol, fr.ipv6_next_header, fr.sport} = {8'h06, 8'h11, 16'd15};
    {fr.frame_dscp, fr.classified_dscp, fr.ip_header_offset} = {6'h11, 6'h22, 8'd14};
    {fr.pointer_at_eth, fr.tag_count, fr.ipv6_dest_low} = {1'b1, 2'd2, 32'h0a0b0c0d};
    pa = {2'h0, 12'h100, 12'h345};
    repeat (12) @(posedge aclk);
    aresetn <= 1;
    rd(STATUS_OFS);
    chk("status", rd_v, 0);
    chk("rresp", rs, RESP_OKAY);
    rd(RNG_TYPE_BASE);
    chk("rng_type", rd_v, RNG_TYPE_RESET);
    rd(8'h08);
    chk("unmapped", rs, RESP_SLVERR);
    wr(CTRL_OFS, 32'h2a11);
    chk("bresp", rs, RESP_OKAY);
    wr(RNG_TYPE_BASE, 0);
    wr(RNG_BOUND_BASE, 32'h0014000a);
    // All key types and next-index codes
    for (int i = 0; i < 5; i++) begin
      pa.next_index_control = 2'(i - 1);
      lk(i[0], i == 0 ? LOW_LATENCY_FULL_KEY : wide_key_type_t'((i - 1) % 3 + 1));
      chk("port", wide_key.logical_ingress_port, i == 0 ? 6'h2a : 6'h0);
      chk("svc", wide_key.service_index_flag, i == 3);
      chk("gidx", wide_key.generic_chain_index, gx[i]);
      chk("dscp", narrow_key.dscp_key_field, i[0] ? 6'h22 : 6'h11);
      chk("rng", narrow_key.range_match_mask, 8'h01);
      chk("post", narrow_key.post_header_payload, 32'h22232425);
      chk("custom", narrow_key.narrow_custom_payload, cexp);
      {fr.length_type_flag, fr.ip_or_snap_flag, fr.ipv4_flag} = fl[i];
      lk(1, NORMAL_KEY);
      chk("src", narrow_key.overloaded_source_field, se[i]);
    end
    pa.next_index_control = NEXT_CTRL_DEFAULT;
    for (int s = 0; s < 3; s++) begin
      wr(CTRL_OFS, 32'h2a01 | (s << 4));
      lk(0, NORMAL_KEY);
      chk("gidx_def", wide_key.generic_chain_index, gx[s+5]);
    end
    end_of_test;
  end
endmodule // testbench
